// ---- test/rclo_core_tb.sv ----
`timescale 1ns/1ps
module rclo_core_tb;
  import rclo_pkg::*;
  logic                clk             = 1'b0;
  logic                reset_n         = 1'b0;
  logic                instr_valid     = 1'b0;
  logic [RCLO_OPW-1:0] instr           = 14'h0000;
  logic [RCLO_PCW-1:0] stack_top_entry = 13'h0000;
  logic                file_wr         = 1'b0;
  logic [RCLO_DW-1:0]  file_wdata      = 8'h00;
  logic                acc_wr          = 1'b0;
  logic [RCLO_DW-1:0]  acc_wdata       = 8'h00;
  logic                intc_wr         = 1'b0;
  logic [RCLO_DW-1:0]  intc_wdata      = 8'h00;
  logic                stack_pop, pc_load, busy;
  logic [RCLO_PCW-1:0] pc_load_value;
  logic [RCLO_DW-1:0]  accumulator, prescaler_cfg, interrupt_control_reg, v, k;
  int                  errors = 0;
  int                  total_checks = 0;
  int                  seed;
  rclo_core u_rclo_core (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .stack_top_entry(stack_top_entry), .file_wr(file_wr), .file_wdata(file_wdata),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .intc_wr(intc_wr), .intc_wdata(intc_wdata),
    .stack_pop(stack_pop), .pc_load_value(pc_load_value), .pc_load(pc_load), .busy(busy),
    .accumulator(accumulator), .prescaler_cfg(prescaler_cfg),
    .interrupt_control_reg(interrupt_control_reg));
  // Free-running instruction clock of 25 ns.
  always #12.5 clk = ~clk;
  // Compares one value and reports a mismatch at once.
  task check(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Moves to just after the next rising edge.
  task step;
    @(posedge clk);
    #2;
  endtask
  // Presents one opcode at the next edge; valid stays up until the caller lowers it.
  task run(input logic [13:0] op);
    instr = op;
    instr_valid = 1'b1;
    step;
  endtask
  // Builds a literal return word with the given don't-care bits.
  function automatic logic [13:0] lit_op(input logic [1:0] dc, input logic [7:0] lit);
    return {4'hd, dc, lit};
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: reset, both returns, configuration load and file writes.
  initial begin
    seed = $urandom(32'h617f);
    repeat (4) @(posedge clk);
    #2 reset_n = 1'b1;
    check(prescaler_cfg, RCLO_PRE_RESET);
    check(interrupt_control_reg, RCLO_INTC_RESET);
    v = 8'($urandom) & 8'h7f;
    intc_wdata = v;
    intc_wr = 1'b1;
    step;
    intc_wr = 1'b0;
    stack_top_entry = 13'($urandom);
    run(RCLO_OP_INT_RETURN);
    check({stack_pop, pc_load, busy}, 13'h0007);
    check(pc_load_value, stack_top_entry);
    check(interrupt_control_reg, v | 8'h80);
    run(RCLO_OP_CFG_LOAD);
    check({stack_pop, busy}, 13'h0000);
    check(prescaler_cfg, RCLO_PRE_RESET);
    instr_valid = 1'b0;
    acc_wdata = 8'($urandom);
    acc_wr = 1'b1;
    step;
    acc_wr = 1'b0;
    // Configuration load and a file write at the same edge: the load wins.
    file_wdata = ~acc_wdata;
    file_wr = 1'b1;
    run(RCLO_OP_CFG_LOAD);
    check(prescaler_cfg, acc_wdata);
    check(busy, 1'b0);
    instr_valid = 1'b0;
    file_wdata = 8'($urandom);
    step;
    file_wr = 1'b0;
    check(prescaler_cfg, file_wdata);
    for (int dc = 0; dc < 4; dc++) begin
      k = 8'($urandom);
      stack_top_entry = 13'($urandom);
      acc_wdata = ~k;
      acc_wr = (dc == 3);
      run(lit_op(2'(dc), k));
      acc_wr = 1'b0;
      check(accumulator, k);
      check({stack_pop, pc_load, busy}, 13'h0007);
      check(pc_load_value, stack_top_entry);
      step;
      check({stack_pop, busy}, 13'h0000);
    end
    // Interrupt return while a file write hits interrupt control: the enable bit wins.
    intc_wdata = 8'($urandom) & 8'h7f;
    intc_wr = 1'b1;
    run(RCLO_OP_INT_RETURN);
    intc_wr = 1'b0;
    check(interrupt_control_reg, intc_wdata | 8'h80);
    step;
    // Opcodes with top bits 1100, 1110 or 1111 are not literal returns and leave all alone.
    for (int top = 12; top < 16; top++) begin
      if (top != 13) begin
        run({4'(top), 2'(top), ~k});
        check({stack_pop, busy}, 13'h0000);
        check(accumulator, k);
      end
    end
    // Reset in mid-run puts every output back to its reset value.
    instr_valid = 1'b0;
    reset_n = 1'b0;
    step;
    check({stack_pop, pc_load, busy}, 13'h0000);
    check(pc_load_value, RCLO_PC_RESET);
    check(accumulator, RCLO_ACC_RESET);
    check(prescaler_cfg, RCLO_PRE_RESET);
    check(interrupt_control_reg, RCLO_INTC_RESET);
    reset_n = 1'b1;
    run(RCLO_OP_CFG_LOAD);
    check(prescaler_cfg, RCLO_ACC_RESET);
    report_and_stop;
  end
endmodule // rclo_core_tb

// ---- verilog/rclo_core.sv ----
`timescale 1ns/1ps
// Function
// - Interrupt return opcode pops stack into program counter, two cycles, flags untouched.
// - Interrupt return sets global interrupt enable, bit 7 of interrupt control.
// - Configuration load opcode copies accumulator into prescaler register in one cycle.
// - Prescaler register also reads and writes as an ordinary file register.
// - Literal return opcode loads its 8-bit literal into accumulator, flags untouched.
// - Literal return also pops stack into program counter, two cycles total.
module rclo_core
  import rclo_pkg::*;
(
  input  wire logic                clk,              // Instruction cycle clock.
  input  wire logic                reset_n,          // Asynchronous reset, active low.
  input  wire logic                instr_valid,      // Opcode on instr is to execute.
  input  wire logic [RCLO_OPW-1:0] instr,            // Fetched opcode.
  input  wire logic [RCLO_PCW-1:0] stack_top_entry,  // Current top of the return stack.
  input  wire logic                file_wr,          // File write to prescaler register.
  input  wire logic [RCLO_DW-1:0]  file_wdata,       // Data for that file write.
  input  wire logic                acc_wr,           // Other unit writes accumulator.
  input  wire logic [RCLO_DW-1:0]  acc_wdata,        // Data for that write.
  input  wire logic                intc_wr,          // File write to interrupt control.
  input  wire logic [RCLO_DW-1:0]  intc_wdata,       // Data for that write.
  output logic                     stack_pop,        // One-cycle pop of return stack.
  output logic [RCLO_PCW-1:0]      pc_load_value,    // Address loaded into program counter.
  output logic                     pc_load,          // Program counter load strobe.
  output logic                     busy,             // Second cycle of a return.
  output logic [RCLO_DW-1:0]       accumulator,      // Working accumulator.
  output logic [RCLO_DW-1:0]       prescaler_cfg,    // Prescaler configuration register.
  output logic [RCLO_DW-1:0]       interrupt_control_reg // Interrupt control register.
);

  // Registered state and the decode strobes of the execute cycle.
  rclo_state_e         state_q;
  logic [RCLO_DW-1:0]  acc_q;
  logic [RCLO_DW-1:0]  pre_q;
  logic [RCLO_DW-1:0]  intc_q;
  logic                pop_q;
  logic                busy_q;
  logic [RCLO_PCW-1:0] pcv_q;
  logic                exec;
  logic                is_iret;
  logic                is_cfg;
  logic                is_lret;

  // Literal return matches on its top four bits; the two bits below them are ignored.
  function automatic logic lit_ret_match(input logic [RCLO_OPW-1:0] op);
    return (op[13:10] & RCLO_LIT_RET_MASK) == (RCLO_LIT_RET_TOP & RCLO_LIT_RET_MASK);
  endfunction

  // Decode happens only in the execute state; the flush cycle discards the fetch.
  assign exec    = instr_valid && (state_q == RCLO_ST_EXEC);
  assign is_iret = exec && (instr == RCLO_OP_INT_RETURN);
  assign is_cfg  = exec && (instr == RCLO_OP_CFG_LOAD);
  assign is_lret = exec && lit_ret_match(instr);

  // Returns take a second cycle to refill the pipeline.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RCLO_ST_EXEC;
    end else begin
      case (state_q)
        RCLO_ST_EXEC: begin
          if (is_iret || is_lret) begin
            state_q <= RCLO_ST_FLUSH;
          end
        end
        RCLO_ST_FLUSH: begin
          state_q <= RCLO_ST_EXEC;
        end
        default: begin
          state_q <= RCLO_ST_EXEC;
        end
      endcase
    end
  end

  // Pop request and return address go out registered, one pulse per return.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pop_q <= 1'b0;
      pcv_q <= RCLO_PC_RESET;
    end else begin
      pop_q <= is_iret || is_lret;
      if (is_iret || is_lret) begin
        pcv_q <= stack_top_entry;
      end
    end
  end

  // Busy has its own flop, set by the edge that takes a return; it marks the flush
  // cycle in which the next fetched opcode is thrown away.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= is_iret || is_lret;
    end
  end

  // Accumulator: the literal return wins over any other writer in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= RCLO_ACC_RESET;
    end else if (is_lret) begin
      acc_q <= instr[RCLO_DW-1:0];
    end else if (acc_wr) begin
      acc_q <= acc_wdata;
    end
  end

  // Prescaler register: dedicated load opcode or ordinary file write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= RCLO_PRE_RESET;
    end else if (is_cfg) begin
      pre_q <= acc_q;
    end else if (file_wr) begin
      pre_q <= file_wdata;
    end
  end

  // Interrupt control: file writes land, then an interrupt return sets the enable bit on top.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intc_q <= RCLO_INTC_RESET;
    end else begin
      if (intc_wr) begin
        intc_q <= intc_wdata;
      end
      if (is_iret) begin
        intc_q[RCLO_GIE_BIT] <= 1'b1;
      end
    end
  end

  // Every output is driven straight from its flop.
  assign stack_pop             = pop_q;
  assign pc_load               = pop_q;
  assign pc_load_value         = pcv_q;
  assign busy                  = busy_q;
  assign accumulator           = acc_q;
  assign prescaler_cfg         = pre_q;
  assign interrupt_control_reg = intc_q;

  // Steps of a return: the edge that takes it, the cycle that answers it with a
  // pop and a flush, and the cycle after that in which the core is free again.
  sequence s_return_taken;
    is_iret || is_lret;
  endsequence

  sequence s_return_answer;
    stack_pop && pc_load && busy;
  endsequence

  sequence s_return_done;
    !stack_pop && !pc_load && !busy;
  endsequence

  // The edge that takes a configuration load.
  sequence s_cfg_taken;
    is_cfg;
  endsequence

  // A return answers with one pop pulse and one flush cycle, then frees the core.
  a_ret_pop_flush: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_return_taken |=> s_return_answer ##1 s_return_done
  ) else $error("return did not give one pop pulse and one flush cycle");

  // The address handed to the program counter is the stack top seen at the taking edge.
  a_ret_pc_value: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_return_taken |=> (pc_load_value == $past(stack_top_entry))
  ) else $error("program counter load value is not the popped stack top");

  // Interrupt return leaves the global interrupt enable set, even over a file write.
  a_iret_gie_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    is_iret |=> interrupt_control_reg[RCLO_GIE_BIT]
  ) else $error("interrupt return left the global interrupt enable clear");

  // Configuration load copies the accumulator and takes no second cycle.
  a_cfg_load_acc: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_cfg_taken |=> (prescaler_cfg == $past(accumulator)) && !busy && !stack_pop
  ) else $error("configuration load did not copy the accumulator in one cycle");

  // An ordinary file write lands in the prescaler register when no load competes.
  a_pre_file_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    (file_wr && !is_cfg) |=> (prescaler_cfg == $past(file_wdata))
  ) else $error("file write to the prescaler register did not land");

  // Literal return puts its literal in the accumulator, over any other writer.
  a_lret_acc_lit: assert property (
    @(posedge clk) disable iff (!reset_n)
    is_lret |=> (accumulator == $past(instr[RCLO_DW-1:0]))
  ) else $error("literal return did not load its literal into the accumulator");

  // Literal return decode follows the top four bits and never the two below them.
  a_lret_decode: assert property (
    @(posedge clk) disable iff (!reset_n)
    exec |-> (is_lret == (instr[RCLO_OPW-1:RCLO_OPW-4] == RCLO_LIT_RET_TOP))
  ) else $error("literal return decode does not follow its top four bits");

  // Opcodes offered in the flush cycle are dropped without any side effect.
  a_flush_drops: assert property (
    @(posedge clk) disable iff (!reset_n)
    (busy && !acc_wr && !file_wr) |=>
      $stable(accumulator) && $stable(prescaler_cfg) && !stack_pop
  ) else $error("an opcode offered in the flush cycle was executed");

  // The flush cycle of a return lasts exactly one cycle.
  a_busy_one_cycle: assert property (
    @(posedge clk) disable iff (!reset_n)
    busy |=> !busy
  ) else $error("flush cycle lasted more than one cycle");

  // The state register only ever holds one of its one-hot codes.
  a_state_onehot: assert property (
    @(posedge clk) disable iff (!reset_n)
    $onehot(state_q)
  ) else $error("execution state left its one-hot codes");
endmodule // rclo_core

// ---- verilog/rclo_pkg.sv ----
package rclo_pkg;

  // Instruction word and data widths of the core.
  localparam int RCLO_OPW = 14;
  localparam int RCLO_DW  = 8;
  localparam int RCLO_PCW = 13;

  // Fixed encodings of the two no-operand instructions.
  localparam logic [13:0] RCLO_OP_INT_RETURN = 14'h0009;
  localparam logic [13:0] RCLO_OP_CFG_LOAD   = 14'h0062;

  // Literal return: top four bits 1101; the two bits below them are don't care.
  localparam logic [3:0]  RCLO_LIT_RET_TOP  = 4'hd;
  localparam logic [3:0]  RCLO_LIT_RET_MASK = 4'hf;

  // Bit position of the global interrupt enable in the interrupt control register.
  localparam int RCLO_GIE_BIT = 7;

  // Instruction cycles taken by each return.
  localparam int RCLO_RET_CYCLES = 2;

  // Values after reset.
  localparam logic [7:0]  RCLO_ACC_RESET  = 8'h00;
  localparam logic [7:0]  RCLO_PRE_RESET  = 8'hff;
  localparam logic [7:0]  RCLO_INTC_RESET = 8'h00;
  localparam logic [12:0] RCLO_PC_RESET   = 13'h0000;

  // Execution states.
  typedef enum logic [1:0] {
    RCLO_ST_EXEC  = 2'b01,
    RCLO_ST_FLUSH = 2'b10
  } rclo_state_e;

endpackage
